// File: hw/udc_ctrl_regs.vh
`ifndef UDC_CTRL_REGS_VH
`define UDC_CTRL_REGS_VH

// Register indices on the plain register port
`define UDC_ADDR_W            4
`define UDC_IDX_IRQ_EN        4'h0
`define UDC_IDX_IRQ_FLAGS     4'h1
`define UDC_IDX_DEV_ADDR      4'h2
`define UDC_IDX_FRAME_HI      4'h3
`define UDC_IDX_FRAME_LO      4'h4
`define UDC_IDX_FRAME_ERR     4'h5
`define UDC_IDX_EP_SELECT     4'h6
`define UDC_IDX_EP_RESET      4'h7
`define UDC_IDX_EP_CTRL       4'h8
`define UDC_IDX_EP_CFG0       4'h9
`define UDC_IDX_EP_CFG1       4'hA
`define UDC_IDX_CTRL_IN       4'hB

// Writable bit masks, reserved bits read as zero
`define UDC_IRQ_EN_MASK       8'h3D
`define UDC_DEV_ADDR_MASK     8'hFF
`define UDC_EP_RESET_MASK     8'h1F
`define UDC_EP_CFG0_MASK      8'hC1
`define UDC_EP_CFG1_MASK      8'h7C

// Field positions
`define UDC_BIT_RESUME_END    5
`define UDC_BIT_BUS_ACTIVITY  4
`define UDC_BIT_BUS_RESET_END 3
`define UDC_BIT_FRAME_START   2
`define UDC_BIT_IDLE_SUSPEND  0
`define UDC_BIT_ADDR_VALID    7
`define UDC_BIT_FRAME_CRC_ERR 4
`define UDC_BIT_STALL_REQ     5
`define UDC_BIT_STALL_CANCEL  4
`define UDC_BIT_TOGGLE_RESET  3
`define UDC_BIT_EP_ACTIVE     0
`define UDC_BIT_EP_DIR        0

// Endpoint type codes
`define UDC_TYPE_CONTROL      2'h0
`define UDC_TYPE_ISO          2'h1
`define UDC_TYPE_BULK         2'h2
`define UDC_TYPE_INTR         2'h3

// Bank count codes
`define UDC_BANKS_ONE         2'h0
`define UDC_BANKS_TWO         2'h1

// Idle time before suspend
`define UDC_SUSPEND_US        3000
`define UDC_CLK_MHZ           100

`endif

// File: hw/udc_idle_timer.v
`timescale 1ns/1ps
`default_nettype none

module udc_idle_timer
#(
    parameter CNT_W      = 19,
    parameter IDLE_LIMIT = 300000
)
(
    input  wire sys_clk,
    input  wire nrst,
    input  wire bus_idle,
    output reg  suspend_pulse
);

    reg [CNT_W-1:0] count_reg;
    reg             fired_reg;

    // ----------------------------------------
    // Idle counter, one pulse per idle period
    // ----------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg     <= {CNT_W{1'b0}};
            fired_reg     <= 1'b0;
            suspend_pulse <= 1'b0;
        end
        else if (!bus_idle)
        begin
            count_reg     <= {CNT_W{1'b0}};
            fired_reg     <= 1'b0;
            suspend_pulse <= 1'b0;
        end
        else
        begin
            suspend_pulse <= 1'b0;
            if (count_reg < IDLE_LIMIT[CNT_W-1:0])
            begin
                count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            else if (!fired_reg)
            begin
                fired_reg     <= 1'b1;
                suspend_pulse <= 1'b1; // RULE_21
            end
        end
    end

endmodule

`default_nettype wire

// File: hw/udc_ctrl.v
// How it works
// RULE_01: Five writable general interrupt enable bits.
// RULE_02: Interrupt needs enable, global flag, event.
// RULE_03: Reserved bits always read as zero.
// RULE_04: Answer programmed address once enable set.
// RULE_05: Software writes address, then sets enable.
// RULE_06: Frame number from latest frame start.
// RULE_07: Corrupt frame start still updates number.
// RULE_08: Bad frame CRC sets start and error.
// RULE_09: Selector routes endpoint register accesses.
// RULE_10: Endpoint held reset while bit one.
// RULE_11: Stall request answers next SETUP, self-clears.
// RULE_12: Stall cancel clears request, self-clears.
// RULE_13: Toggle reset clears endpoint toggle, self-clears.
// RULE_14: Active bit enables or disables endpoint.
// RULE_15: Software enables endpoint zero after resets.
// RULE_16: Type field: control, iso, bulk, interrupt.
// RULE_17: Direction bit ignored for control endpoints.
// RULE_18: Size codes give 8 to 64 bytes.
// RULE_19: Bank codes give one or two banks.
// RULE_20: Event flags set regardless of enables.
// RULE_21: Idle over 3 ms sets suspend.
// RULE_22: Enables and configuration reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "udc_ctrl_regs.vh"

module udc_ctrl
#(
    parameter NUM_EP     = 5,
    parameter EP_W       = 3,
    parameter IDLE_CNT_W = 19,
    parameter IDLE_LIMIT = `UDC_SUSPEND_US * `UDC_CLK_MHZ
)
(
    input  wire                  sys_clk,
    input  wire                  nrst,
    input  wire [`UDC_ADDR_W-1:0] reg_addr,
    input  wire [7:0]            reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output reg  [7:0]            reg_rdata,
    input  wire                  global_irq_enable,
    input  wire                  resume_end_in,
    input  wire                  bus_activity_in,
    input  wire                  bus_reset_end_in,
    input  wire                  bus_idle,
    input  wire                  frame_start_in,
    input  wire                  frame_crc_bad_in,
    input  wire [10:0]           frame_count_in,
    input  wire [6:0]            token_addr,
    input  wire                  token_valid,
    input  wire [EP_W-1:0]       token_ep,
    input  wire                  setup_token,
    input  wire                  stall_sent,
    output reg                   general_irq,
    output reg                   address_match,
    output reg                   stall_answer,
    output reg  [NUM_EP-1:0]     ep_active_out,
    output reg  [NUM_EP-1:0]     ep_hold_reset_out,
    output reg  [NUM_EP-1:0]     toggle_clear_pulse,
    output reg  [1:0]            sel_ep_type,
    output reg                   sel_ep_dir_in,
    output reg  [6:0]            sel_ep_size_bytes,
    output reg  [1:0]            sel_ep_banks,
    output reg                   sel_ep_cfg_valid
);

    reg [7:0]        irq_en_reg;
    reg [7:0]        irq_flags_reg;
    reg [7:0]        dev_addr_reg;
    reg [10:0]       frame_count_reg;
    reg              frame_crc_error_reg;
    reg [EP_W-1:0]   ep_sel_reg;
    reg [4:0]        ep_reset_reg;
    reg [NUM_EP-1:0] stall_req_reg;
    reg [NUM_EP-1:0] ep_active_reg;
    reg [1:0]        ep_type_reg [0:NUM_EP-1];
    reg              ep_dir_reg  [0:NUM_EP-1];
    reg [2:0]        ep_size_reg [0:NUM_EP-1];
    reg [1:0]        ep_bank_reg [0:NUM_EP-1];
    reg [7:0]        rdata_next;
    wire             suspend_pulse;
    wire             wr_ep;
    wire [7:0]       ev_now;
    integer          i;
    integer          k;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function [6:0] size_bytes;
        input [2:0] code;
        begin
            case (code)
                3'h0:    size_bytes = 7'h08; // RULE_18
                3'h1:    size_bytes = 7'h10;
                3'h2:    size_bytes = 7'h20;
                3'h3:    size_bytes = 7'h40;
                default: size_bytes = 7'h00;
            endcase
        end
    endfunction

    function [1:0] bank_count;
        input [1:0] code;
        begin
            case (code)
                `UDC_BANKS_ONE: bank_count = 2'h1; // RULE_19
                `UDC_BANKS_TWO: bank_count = 2'h2;
                default:        bank_count = 2'h0;
            endcase
        end
    endfunction

    function is_wr;
        input [`UDC_ADDR_W-1:0] idx;
        begin
            is_wr = reg_wr && (reg_addr == idx);
        end
    endfunction

    // ----------------------------------------
    // Suspend idle timer
    // ----------------------------------------
    udc_idle_timer
    #(
        .CNT_W      (IDLE_CNT_W),
        .IDLE_LIMIT (IDLE_LIMIT)
    )
    u_idle
    (
        .sys_clk       (sys_clk),
        .nrst          (nrst),
        .bus_idle      (bus_idle),
        .suspend_pulse (suspend_pulse)
    );

    assign wr_ep = {{(32-EP_W){1'b0}}, ep_sel_reg} < NUM_EP;

    // Hardware events, mapped onto flag positions
    assign ev_now = {2'h0, resume_end_in, bus_activity_in, bus_reset_end_in,
                     frame_start_in | frame_crc_bad_in, 1'b0, suspend_pulse}; // RULE_08

    // ----------------------------------------
    // General registers and event flags
    // ----------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_en_reg          <= 8'h00; // RULE_22
            irq_flags_reg       <= 8'h00;
            dev_addr_reg        <= 8'h00;
            frame_count_reg     <= 11'h000;
            frame_crc_error_reg <= 1'b0;
            ep_sel_reg          <= {EP_W{1'b0}};
            ep_reset_reg        <= 5'h00;
        end
        else
        begin
            if (is_wr(`UDC_IDX_IRQ_EN))
                irq_en_reg <= reg_wdata & `UDC_IRQ_EN_MASK; // RULE_01
            // Software clears by writing zero; a new event wins
            irq_flags_reg <= (is_wr(`UDC_IDX_IRQ_FLAGS) ?
                              (irq_flags_reg & reg_wdata) : irq_flags_reg)
                             | (ev_now & `UDC_IRQ_EN_MASK); // RULE_20
            if (is_wr(`UDC_IDX_DEV_ADDR))
                dev_addr_reg <= reg_wdata & `UDC_DEV_ADDR_MASK;
            if (frame_start_in || frame_crc_bad_in)
                frame_count_reg <= frame_count_in; // RULE_06 RULE_07
            if (frame_crc_bad_in)
                frame_crc_error_reg <= 1'b1; // RULE_08
            else if (frame_start_in)
                frame_crc_error_reg <= 1'b0;
            if (is_wr(`UDC_IDX_EP_SELECT))
                ep_sel_reg <= reg_wdata[EP_W-1:0]; // RULE_09
            if (is_wr(`UDC_IDX_EP_RESET))
                ep_reset_reg <= reg_wdata[4:0]; // RULE_10
        end
    end

    // ----------------------------------------
    // Per-endpoint control and configuration
    // ----------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stall_req_reg      <= {NUM_EP{1'b0}};
            ep_active_reg      <= {NUM_EP{1'b0}};
            toggle_clear_pulse <= {NUM_EP{1'b0}};
            for (i = 0; i < NUM_EP; i = i + 1)
            begin
                ep_type_reg[i] <= 2'h0; // RULE_22
                ep_dir_reg[i]  <= 1'b0;
                ep_size_reg[i] <= 3'h0;
                ep_bank_reg[i] <= 2'h0;
            end
        end
        else
        begin
            toggle_clear_pulse <= {NUM_EP{1'b0}};
            for (i = 0; i < NUM_EP; i = i + 1)
            begin
                // Hardware clears on stall sent or new SETUP
                if (token_valid && (token_ep == i[EP_W-1:0]) && (setup_token || stall_sent))
                    stall_req_reg[i] <= 1'b0; // RULE_11
                if (i < 5 && ep_reset_reg[i])
                    stall_req_reg[i] <= 1'b0; // RULE_10
            end
            if (wr_ep && is_wr(`UDC_IDX_EP_CTRL))
            begin
                if (reg_wdata[`UDC_BIT_STALL_REQ])
                    stall_req_reg[ep_sel_reg] <= 1'b1; // RULE_11
                if (reg_wdata[`UDC_BIT_STALL_CANCEL])
                    stall_req_reg[ep_sel_reg] <= 1'b0; // RULE_12
                if (reg_wdata[`UDC_BIT_TOGGLE_RESET])
                    toggle_clear_pulse[ep_sel_reg] <= 1'b1; // RULE_13
                ep_active_reg[ep_sel_reg] <= reg_wdata[`UDC_BIT_EP_ACTIVE]; // RULE_14
            end
            if (wr_ep && is_wr(`UDC_IDX_EP_CFG0))
            begin
                ep_type_reg[ep_sel_reg] <= reg_wdata[7:6]; // RULE_16
                ep_dir_reg[ep_sel_reg]  <= reg_wdata[`UDC_BIT_EP_DIR];
            end
            if (wr_ep && is_wr(`UDC_IDX_EP_CFG1))
            begin
                ep_size_reg[ep_sel_reg] <= reg_wdata[6:4];
                ep_bank_reg[ep_sel_reg] <= reg_wdata[3:2];
            end
        end
    end

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    always @*
    begin
        rdata_next = 8'h00; // RULE_03
        case (reg_addr)
            `UDC_IDX_IRQ_EN:    rdata_next = irq_en_reg;
            `UDC_IDX_IRQ_FLAGS: rdata_next = irq_flags_reg;
            `UDC_IDX_DEV_ADDR:  rdata_next = dev_addr_reg;
            `UDC_IDX_FRAME_HI:  rdata_next = {5'h00, frame_count_reg[10:8]}; // RULE_06
            `UDC_IDX_FRAME_LO:  rdata_next = frame_count_reg[7:0];
            `UDC_IDX_FRAME_ERR: rdata_next = {3'h0, frame_crc_error_reg, 4'h0};
            `UDC_IDX_EP_SELECT: rdata_next = {{(8-EP_W){1'b0}}, ep_sel_reg};
            `UDC_IDX_EP_RESET:  rdata_next = {3'h0, ep_reset_reg};
            `UDC_IDX_EP_CTRL:
                if (wr_ep)
                    rdata_next = {2'h0, stall_req_reg[ep_sel_reg], 4'h0,
                                  ep_active_reg[ep_sel_reg]}; // RULE_09 RULE_12
            `UDC_IDX_EP_CFG0:
                if (wr_ep)
                    rdata_next = {ep_type_reg[ep_sel_reg], 5'h00, ep_dir_reg[ep_sel_reg]};
            `UDC_IDX_EP_CFG1:
                if (wr_ep)
                    rdata_next = {1'b0, ep_size_reg[ep_sel_reg], ep_bank_reg[ep_sel_reg], 2'h0};
            `UDC_IDX_CTRL_IN:   rdata_next = {7'h00, global_irq_enable};
            default:            rdata_next = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata         <= 8'h00;
            general_irq       <= 1'b0;
            address_match     <= 1'b0;
            stall_answer      <= 1'b0;
            ep_active_out     <= {NUM_EP{1'b0}};
            ep_hold_reset_out <= {NUM_EP{1'b0}};
            sel_ep_type       <= 2'h0;
            sel_ep_dir_in     <= 1'b0;
            sel_ep_size_bytes <= 7'h00;
            sel_ep_banks      <= 2'h0;
            sel_ep_cfg_valid  <= 1'b0;
        end
        else
        begin
            reg_rdata     <= reg_rd ? rdata_next : 8'h00;
            general_irq   <= global_irq_enable && |(irq_en_reg & irq_flags_reg); // RULE_02
            address_match <= token_valid && dev_addr_reg[`UDC_BIT_ADDR_VALID]
                             && (token_addr == dev_addr_reg[6:0]); // RULE_04
            stall_answer  <= token_valid && setup_token && ({{(32-EP_W){1'b0}}, token_ep} < NUM_EP)
                             && stall_req_reg[token_ep]; // RULE_11
            ep_active_out <= ep_active_reg;
            for (k = 0; k < NUM_EP; k = k + 1)
                ep_hold_reset_out[k] <= (k < 5) ? ep_reset_reg[k] : 1'b0; // RULE_10
            if (wr_ep)
            begin
                sel_ep_type       <= ep_type_reg[ep_sel_reg];
                sel_ep_dir_in     <= (ep_type_reg[ep_sel_reg] != `UDC_TYPE_CONTROL)
                                     && ep_dir_reg[ep_sel_reg]; // RULE_17
                sel_ep_size_bytes <= size_bytes(ep_size_reg[ep_sel_reg]);
                sel_ep_banks      <= bank_count(ep_bank_reg[ep_sel_reg]);
                sel_ep_cfg_valid  <= (size_bytes(ep_size_reg[ep_sel_reg]) != 7'h00)
                                     && (bank_count(ep_bank_reg[ep_sel_reg]) != 2'h0);
            end
            else
            begin
                sel_ep_type       <= 2'h0;
                sel_ep_dir_in     <= 1'b0;
                sel_ep_size_bytes <= 7'h00;
                sel_ep_banks      <= 2'h0;
                sel_ep_cfg_valid  <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: verif/udc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module udc_ctrl_asserts
#(
    parameter NUM_EP = 5
)
(
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic [3:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              global_irq_enable,
    input wire logic              token_valid,
    input wire logic              setup_token,
    input wire logic              general_irq,
    input wire logic              address_match,
    input wire logic              stall_answer,
    input wire logic [NUM_EP-1:0] toggle_clear_pulse,
    input wire logic [1:0]        sel_ep_type,
    input wire logic              sel_ep_dir_in,
    input wire logic [6:0]        sel_ep_size_bytes,
    input wire logic [1:0]        sel_ep_banks
);
    // ----------------
    // Port checks
    // ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    hi_rsvd_a: assert property ($past(reg_rd && reg_addr == 4'h3) |-> reg_rdata[7:3] == 5'h00)
        else $error("frame high reserved bits set");
    irq_gate_a: assert property (general_irq |-> $past(global_irq_enable))
        else $error("interrupt without global flag");
    addr_hit_a: assert property (address_match |-> $past(token_valid))
        else $error("address match without token");
    stall_ans_a: assert property (stall_answer |-> $past(token_valid && setup_token))
        else $error("stall answer without setup");
    ctrl_selfclr_a: assert property ($past(reg_rd && reg_addr == 4'h8) |-> reg_rdata[4:3] == 2'h0)
        else $error("self clearing bits read as one");
    toggle_pulse_a: assert property (|toggle_clear_pulse |-> $past(reg_wr && reg_addr == 4'h8 && reg_wdata[3]))
        else $error("toggle clear without write");
    ctrl_dir_a: assert property (sel_ep_type == 2'h0 |-> !sel_ep_dir_in)
        else $error("direction shown for control");
    size_code_a: assert property (sel_ep_size_bytes inside {7'h00, 7'h08, 7'h10, 7'h20, 7'h40})
        else $error("bad packet size");
    bank_code_a: assert property (sel_ep_banks != 2'h3)
        else $error("bad bank count");
    cover property (address_match);
    cover property (stall_answer);
    cover property (general_irq);
endmodule
bind udc_ctrl udc_ctrl_asserts #(.NUM_EP(NUM_EP)) u_chk (.*);
`default_nettype wire

// File: verif/udc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module udc_host_model
#(
    parameter IDLE_LIMIT = 50
)
(
    input  wire logic   sys_clk,
    output logic        resume_end_in,
    output logic        bus_activity_in,
    output logic        bus_reset_end_in,
    output logic        bus_idle,
    output logic        frame_start_in,
    output logic        frame_crc_bad_in,
    output logic [10:0] frame_count_in,
    output logic [6:0]  token_addr,
    output logic        token_valid,
    output logic [2:0]  token_ep,
    output logic        setup_token,
    output logic        stall_sent
);
    // ----------------
    // Bus events
    // ----------------
    initial
    begin
        {resume_end_in, bus_activity_in, bus_reset_end_in, bus_idle} = 4'h0;
        {frame_start_in, frame_crc_bad_in, token_valid, setup_token, stall_sent} = 5'h00;
        frame_count_in = 11'h000;
        token_addr = 7'h00;
        token_ep = 3'h0;
    end
    task automatic ev(input int b);
        @(posedge sys_clk);
        if (b == 0)
        begin
            bus_idle <= 1'b1;
            repeat (IDLE_LIMIT + 6) @(posedge sys_clk);
            bus_idle <= 1'b0;
        end
        else
        begin
            resume_end_in <= (b == 5);
            bus_activity_in <= (b == 4);
            bus_reset_end_in <= (b == 3);
            @(posedge sys_clk);
            {resume_end_in, bus_activity_in, bus_reset_end_in} <= 3'h0;
        end
    endtask
    task automatic frame(input logic [10:0] n, input logic bad);
        @(posedge sys_clk);
        frame_count_in <= n;
        frame_start_in <= !bad;
        frame_crc_bad_in <= bad;
        @(posedge sys_clk);
        {frame_start_in, frame_crc_bad_in} <= 2'h0;
        frame_count_in <= ~n;
    endtask
    task automatic token(input logic [6:0] a, input logic [2:0] ep, input logic s);
        @(posedge sys_clk);
        token_addr <= a;
        token_ep <= ep;
        setup_token <= s;
        token_valid <= 1'b1;
        @(posedge sys_clk);
        token_valid <= 1'b0;
        token_addr <= ~a;
        token_ep <= ~ep;
        setup_token <= ~s;
    endtask
    task automatic stall_done(input logic [2:0] ep);
        @(posedge sys_clk);
        token_ep <= ep;
        setup_token <= 1'b0;
        stall_sent <= 1'b1;
        token_valid <= 1'b1;
        @(posedge sys_clk);
        token_valid <= 1'b0;
        stall_sent <= 1'b0;
        token_ep <= ~ep;
    endtask
endmodule
`default_nettype wire

// File: verif/tb_usb_device_endpoint_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_endpoint_control;
    localparam LIM = 50;
    logic        sys_clk, nrst, reg_wr, reg_rd, global_irq_enable;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    wire  [7:0]  reg_rdata;
    wire         resume_end_in, bus_activity_in, bus_reset_end_in, bus_idle;
    wire         frame_start_in, frame_crc_bad_in, token_valid, setup_token, stall_sent;
    wire  [10:0] frame_count_in;
    wire  [6:0]  token_addr, sel_ep_size_bytes;
    wire  [2:0]  token_ep;
    wire         general_irq, address_match, stall_answer, sel_ep_dir_in, sel_ep_cfg_valid;
    wire  [4:0]  ep_active_out, ep_hold_reset_out, toggle_clear_pulse;
    wire  [1:0]  sel_ep_type, sel_ep_banks;
    int          errors = 0, check_count = 0, cycles = 0;
    int          bits[5] = '{5, 4, 3, 2, 0};
    udc_ctrl #(.IDLE_LIMIT(LIM)) dut (.*);
    udc_host_model #(.IDLE_LIMIT(LIM)) host (.*);
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        for (int i = 0; i < 16; i++)
            rdc(i[3:0], 8'h00);
        wr(4'h8, 8'h01);
        settle;
        chk(ep_active_out, 5'h01);
    endtask
    task automatic t_irq;
        wr(4'h0, 8'hFF);
        rdc(4'h0, 8'h3D);
        wr(4'h0, 8'h00);
        global_irq_enable <= 1'b1;
        rdc(4'hB, 8'h01);
        foreach (bits[k])
        begin
            if (bits[k] == 2)
                host.frame(11'h000, 1'b0);
            else
                host.ev(bits[k]);
            rdc(4'h1, 8'h01 << bits[k]);
            chk(general_irq, 1'b0);
            wr(4'h0, 8'h01 << bits[k]);
            settle;
            chk(general_irq, 1'b1);
            global_irq_enable <= 1'b0;
            settle;
            chk(general_irq, 1'b0);
            global_irq_enable <= 1'b1;
            wr(4'h0, 8'h00);
            wr(4'h1, 8'h00);
        end
        global_irq_enable <= 1'b0;
    endtask
    task automatic t_addr;
        wr(4'h2, 8'h2A);
        host.token(7'h2A, 3'h0, 1'b0);
        #1;
        chk(address_match, 1'b0);
        wr(4'h2, 8'hAA);
        rdc(4'h2, 8'hAA);
        host.token(7'h2A, 3'h0, 1'b0);
        #1;
        chk(address_match, 1'b1);
        host.token(7'h2B, 3'h0, 1'b0);
        #1;
        chk(address_match, 1'b0);
    endtask
    task automatic t_frame;
        host.frame(11'h5A3, 1'b0);
        rdc(4'h3, 8'h05);
        rdc(4'h4, 8'hA3);
        rdc(4'h5, 8'h00);
        wr(4'h1, 8'h00);
        host.frame(11'h7FF, 1'b1);
        rdc(4'h3, 8'h07);
        rdc(4'h4, 8'hFF);
        rdc(4'h5, 8'h10);
        rdc(4'h1, 8'h04);
        wr(4'h1, 8'h00);
    endtask
    task automatic t_ep;
        wr(4'h6, 8'hFA);
        rdc(4'h6, 8'h02);
        wr(4'h9, 8'hFF);
        rdc(4'h9, 8'hC1);
        wr(4'hA, 8'hFF);
        rdc(4'hA, 8'h7C);
        settle;
        chk(sel_ep_size_bytes, 7'h00);
        chk(sel_ep_banks, 2'h0);
        chk(sel_ep_cfg_valid, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h9, {i[1:0], 6'h01});
            wr(4'hA, {1'b0, i[2:0], 4'h4});
            settle;
            chk(sel_ep_type, i[1:0]);
            chk(sel_ep_dir_in, i != 0);
            chk(sel_ep_size_bytes, 7'h08 << i);
            chk(sel_ep_banks, 2'h2);
            chk(sel_ep_cfg_valid, 1'b1);
        end
        wr(4'h6, 8'h03);
        rdc(4'h9, 8'h00);
        wr(4'h6, 8'h05);
        wr(4'h9, 8'hC1);
        rdc(4'h9, 8'h00);
        wr(4'h6, 8'h02);
        rdc(4'h9, 8'hC1);
    endtask
    task automatic t_stall;
        wr(4'h6, 8'h01);
        wr(4'h8, 8'h21);
        settle;
        chk(ep_active_out, 5'h03);
        wr(4'h8, 8'h01);
        rdc(4'h8, 8'h21);
        host.token(7'h2A, 3'h1, 1'b1);
        #1;
        chk(stall_answer, 1'b1);
        rdc(4'h8, 8'h01);
        wr(4'h8, 8'h21);
        wr(4'h8, 8'h11);
        rdc(4'h8, 8'h01);
        host.token(7'h2A, 3'h1, 1'b1);
        #1;
        chk(stall_answer, 1'b0);
        wr(4'h8, 8'h21);
        host.stall_done(3'h1);
        rdc(4'h8, 8'h01);
        wr(4'h8, 8'h09);
        #1;
        chk(toggle_clear_pulse, 5'h02);
        rdc(4'h8, 8'h01);
        wr(4'h8, 8'h00);
        settle;
        chk(ep_active_out, 5'h01);
    endtask
    task automatic t_endpoint_hold_reset;
        wr(4'h8, 8'h21);
        wr(4'h7, 8'hFF);
        rdc(4'h7, 8'h1F);
        chk(ep_hold_reset_out, 5'h1F);
        rdc(4'h8, 8'h01);
        wr(4'h7, 8'h00);
        settle;
        chk(ep_hold_reset_out, 5'h00);
    endtask
    // ----------------
    // Run control
    // ----------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        {nrst, reg_wr, reg_rd, global_irq_enable} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset;
        t_irq;
        t_addr;
        t_frame;
        t_ep;
        t_stall;
        t_endpoint_hold_reset;
        tally_and_finish;
    end
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish;
        end
    end
endmodule
`default_nettype wire
